// ==== fpc_pkg.sv ====
// Purpose: Shared constants, carriers and the bus-cycle engine of the flash programmer controller.
// Assumes: One 40 MHz clock; flash pins are sampled synchronously to it.
// Notes:   The bus-cycle engine shares this file with the package.
// Functional notes
// - Sequences open AA at 5555, 55 at AAAA.
// - Command words have a zero upper byte.
// - Program: unlock, A0, then one word.
// - Erases and protect take six write cycles.
// - Verify reads with bit 5 low, bit 0 high.
// - Security on: unlock, A0, 98 at 0000.
// - Security off: chip erase form, pin high.
// - Security pin high only for security commands.
// - After timeout only reset recovers device; a read returns status.
`default_nettype none

package fpc_pkg;
  // Bus-cycle timing: strobe covers the command cycle and access time, hold covers address hold.
  localparam int unsigned CLK_NS    = 25;
  localparam int unsigned STROBE_NS = 120;
  localparam int unsigned HOLD_NS   = 50;
  localparam logic [2:0]  STROBE_CYC = 3'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0]  HOLD_CYC   = 3'((HOLD_NS + CLK_NS - 1) / CLK_NS);

  // Unlock pattern and command words.
  localparam logic [17:0] UNLOCK1_ADDR = 18'h05555;
  localparam logic [17:0] UNLOCK2_ADDR = 18'h0AAAA;
  localparam logic [17:0] ZERO_ADDR    = 18'h00000;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] CODE_RESET   = 16'h00F0;
  localparam logic [15:0] CODE_PROGRAM = 16'h00A0;
  localparam logic [15:0] CODE_ERASE   = 16'h0080;
  localparam logic [15:0] CODE_CHIP    = 16'h0010;
  localparam logic [15:0] CODE_BLOCK   = 16'h0030;
  localparam logic [15:0] CODE_PROTECT = 16'h009A;
  localparam logic [15:0] CODE_VERIFY  = 16'h0090;
  localparam logic [15:0] CODE_SEC_ON  = 16'h0098;

  // Controller command numbers written by software.
  localparam logic [3:0] CMD_READ    = 4'h0;
  localparam logic [3:0] CMD_RST1    = 4'h1;
  localparam logic [3:0] CMD_RST3    = 4'h2;
  localparam logic [3:0] CMD_PROG    = 4'h3;
  localparam logic [3:0] CMD_CHIP    = 4'h4;
  localparam logic [3:0] CMD_BLOCK   = 4'h5;
  localparam logic [3:0] CMD_PROTECT = 4'h6;
  localparam logic [3:0] CMD_VERIFY  = 4'h7;
  localparam logic [3:0] CMD_SEC_ON  = 4'h8;
  localparam logic [3:0] CMD_SEC_OFF = 4'h9;
  localparam logic [3:0] CMD_LAST    = 4'h9;

  // APB register byte offsets and reset values.
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_WDATA   = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_RDATA   = 8'h10;
  localparam logic [7:0] OFS_PINCTRL = 8'h14;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_READY_BIT = 1;
  localparam int unsigned ST_REFUSED_BIT = 2;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

  typedef struct packed {
    logic        is_read;
    logic        last;
    logic [17:0] addr;
    logic [15:0] data;
  } fpc_cyc_type;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [17:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe_n;
  } fpc_bus_type;

  typedef struct packed {
    fpc_bus_type bus;
    logic        rst_n;
    logic        security_access_pin;
  } fpc_pins_type;

  // Reads and resets must run even while the device reports busy.
  function automatic logic fpc_needs_ready(input logic [3:0] cmd);
    return !(cmd == CMD_READ || cmd == CMD_RST1 || cmd == CMD_RST3);
  endfunction

  function automatic logic fpc_is_security(input logic [3:0] cmd);
    return cmd == CMD_SEC_ON || cmd == CMD_SEC_OFF;
  endfunction

  // Third-cycle command word of each unlocked sequence.
  function automatic logic [15:0] fpc_code(input logic [3:0] cmd);
    logic [15:0] c;
    c = CODE_ERASE;
    if (cmd == CMD_PROG || cmd == CMD_SEC_ON) c = CODE_PROGRAM;
    else if (cmd == CMD_PROTECT) c = CODE_PROTECT;
    else if (cmd == CMD_VERIFY) c = CODE_VERIFY;
    else if (cmd == CMD_RST3) c = CODE_RESET;
    return c;
  endfunction

  // Bus cycle number idx of command cmd; loc and word are the software location and data.
  function automatic fpc_cyc_type fpc_step(input logic [3:0] cmd, input logic [2:0] idx,
                                           input logic [17:0] loc, input logic [15:0] word);
    fpc_cyc_type c;
    c = '{is_read: 1'b0, last: 1'b0, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
    if (idx == 3'd0 && cmd == CMD_READ) begin
      c = '{is_read: 1'b1, last: 1'b1, addr: loc, data: 16'h0000};
    end else if (idx == 3'd0 && cmd == CMD_RST1) begin
      c = '{is_read: 1'b0, last: 1'b1, addr: loc, data: CODE_RESET};
    end else if (idx == 3'd1 || idx == 3'd4) begin
      c.addr = UNLOCK2_ADDR;
      c.data = UNLOCK2_DATA;
    end else if (idx == 3'd2) begin
      c.data = fpc_code(cmd);
      c.last = (cmd == CMD_RST3);
    end else if (idx == 3'd3 && cmd == CMD_PROG) begin
      c = '{is_read: 1'b0, last: 1'b1, addr: loc, data: word};
    end else if (idx == 3'd3 && cmd == CMD_VERIFY) begin
      c = '{is_read: 1'b1, last: 1'b1, addr: {loc[17:6], 1'b0, loc[4:1], 1'b1}, data: 16'h0000};
    end else if (idx == 3'd3 && cmd == CMD_SEC_ON) begin
      c = '{is_read: 1'b0, last: 1'b1, addr: ZERO_ADDR, data: CODE_SEC_ON};
    end else if (idx == 3'd5) begin
      c.last = 1'b1;
      c.data = (cmd == CMD_BLOCK) ? CODE_BLOCK : (cmd == CMD_PROTECT) ? CODE_PROTECT : CODE_CHIP;
      if (cmd == CMD_BLOCK) c.addr = loc;
    end
    return c;
  endfunction
endpackage

// One asynchronous bus cycle: setup, a strobe of STROBE_CYC clocks, then a hold of HOLD_CYC clocks.
module fpc_bus_cycle import fpc_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire fpc_cyc_type cyc,
  input  wire logic [15:0] dq_in,
  output var  fpc_bus_type bus,
  output var  logic        done,
  output var  logic [15:0] rdata
);
  typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} fpc_bc_state_type;

  fpc_bc_state_type state_reg, state_next;
  fpc_bus_type      bus_reg, bus_next;
  logic [2:0]       cnt_reg, cnt_next;
  logic             rd_reg, rd_next;
  logic             done_reg, done_next;
  logic [15:0]      rdata_reg, rdata_next;

  // Address and data settle one clock before the strobe so the device sees them stable.
  always_comb begin
    state_next = state_reg;
    bus_next   = bus_reg;
    cnt_next   = cnt_reg;
    rd_next    = rd_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    unique case (state_reg)
      BC_IDLE: if (req) begin
        bus_next.ce_n    = 1'b0;
        bus_next.addr    = cyc.addr;
        bus_next.dq_out  = cyc.data;
        bus_next.dq_oe_n = cyc.is_read;
        rd_next          = cyc.is_read;
        state_next       = BC_SETUP;
      end
      BC_SETUP: begin
        bus_next.oe_n = ~rd_reg;
        bus_next.we_n = rd_reg;
        cnt_next      = STROBE_CYC - 3'd1;
        state_next    = BC_STROBE;
      end
      BC_STROBE: if (cnt_reg == 3'd0) begin
        bus_next.oe_n = 1'b1;
        bus_next.we_n = 1'b1;
        if (rd_reg) rdata_next = dq_in;
        cnt_next   = HOLD_CYC - 3'd1;
        state_next = BC_HOLD;
      end else begin
        cnt_next = cnt_reg - 3'd1;
      end
      BC_HOLD: if (cnt_reg == 3'd0) begin
        bus_next.ce_n    = 1'b1;
        bus_next.dq_oe_n = 1'b1;
        done_next        = 1'b1;
        state_next       = BC_IDLE;
      end else begin
        cnt_next = cnt_reg - 3'd1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BC_IDLE;
      bus_reg   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 18'h00000, dq_out: 16'h0000, dq_oe_n: 1'b1};
      cnt_reg   <= 3'h0;
      rd_reg    <= 1'b0;
      done_reg  <= 1'b0;
      rdata_reg <= RDATA_RESET;
    end else begin
      state_reg <= state_next;
      bus_reg   <= bus_next;
      cnt_reg   <= cnt_next;
      rd_reg    <= rd_next;
      done_reg  <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  assign bus   = bus_reg;
  assign done  = done_reg;
  assign rdata = rdata_reg;
endmodule

`default_nettype wire

// ==== fpc_top.sv ====
// Purpose: APB-controlled programmer that drives unlock command sequences into a parallel flash.
// Assumes: Zero-wait APB slave; ready_not_busy_pin and dq_in are synchronous to pclk.
// Notes:   Software loads location and word, then writes a command number; status shows progress.
`default_nettype none

module fpc_top import fpc_pkg::*; (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic [31:0]  prdata,
  output var  logic         pready,
  output var  logic         pslverr,
  input  wire logic [15:0]  dq_in,
  input  wire logic         ready_not_busy_pin,
  output var  fpc_pins_type flash_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAITRDY, ST_ISSUE, ST_WAIT} fpc_state_type;

  fpc_state_type state_reg, state_next;
  logic [3:0]    cmd_reg, cmd_next;
  logic [2:0]    idx_reg, idx_next;
  logic [17:0]   loc_reg, loc_next;
  logic [15:0]   word_reg, word_next;
  logic [15:0]   rdata_reg, rdata_next;
  logic          sec_reg, sec_next;
  logic          devrst_reg, devrst_next;
  logic          rst_n_reg, rst_n_next;
  logic          refused_reg, refused_next;
  logic          ready_reg;
  logic          req_reg, req_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic          pready_reg, pready_next;
  logic          pslverr_reg, pslverr_next;
  logic          busy;
  logic          wr_en;
  logic          bad_write;
  fpc_cyc_type   step;
  fpc_bus_type   bus;
  logic          cyc_done;
  logic [15:0]   cyc_rdata;

  assign busy  = (state_reg != ST_IDLE);
  assign step  = fpc_step(cmd_reg, idx_reg, loc_reg, word_reg);
  assign wr_en = psel & penable & pwrite & pready_reg & ~pslverr_reg;

  // Sequence inputs may not change under a running sequence, so such writes are refused.
  always_comb begin
    bad_write = 1'b0;
    if (pwrite && busy && (paddr == OFS_CMD || paddr == OFS_ADDR || paddr == OFS_WDATA)) bad_write = 1'b1;
    if (pwrite && paddr == OFS_CMD && pwdata[3:0] > CMD_LAST) bad_write = 1'b1;
    if (pwrite && (paddr == OFS_STATUS || paddr == OFS_RDATA)) bad_write = 1'b1;
  end

  // APB slave and sequencer next state; the answer is prepared in the setup cycle.
  always_comb begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    idx_next     = idx_reg;
    loc_next     = loc_reg;
    word_next    = word_reg;
    rdata_next   = rdata_reg;
    sec_next     = sec_reg;
    devrst_next  = devrst_reg;
    refused_next = refused_reg;
    req_next     = 1'b0;
    pready_next  = psel & ~penable;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      pslverr_next = bad_write;
      unique case (paddr)
        OFS_CMD:     prdata_next = {28'h0000000, cmd_reg};
        OFS_ADDR:    prdata_next = {14'h0000, loc_reg};
        OFS_WDATA:   prdata_next = {16'h0000, word_reg};
        OFS_STATUS:  prdata_next = {29'h00000000, refused_reg, ready_reg, busy};
        OFS_RDATA:   prdata_next = {16'h0000, rdata_reg};
        OFS_PINCTRL: prdata_next = {31'h00000000, devrst_reg};
        default: begin
          prdata_next  = 32'h00000000;
          pslverr_next = 1'b1;
        end
      endcase
    end
    if (psel && penable && pready_reg && pslverr_reg && pwrite) refused_next = 1'b1;
    if (wr_en && paddr == OFS_ADDR) loc_next = pwdata[17:0];
    if (wr_en && paddr == OFS_WDATA) word_next = pwdata[15:0];
    if (wr_en && paddr == OFS_PINCTRL) devrst_next = pwdata[0];
    rst_n_next = ~devrst_next;
    unique case (state_reg)
      ST_IDLE: if (wr_en && paddr == OFS_CMD) begin
        cmd_next     = pwdata[3:0];
        idx_next     = 3'd0;
        refused_next = 1'b0;
        sec_next     = fpc_is_security(pwdata[3:0]);
        state_next   = ST_WAITRDY;
      end
      // A busy device drops commands, but reads and resets must still get through.
      ST_WAITRDY: if (ready_reg || !fpc_needs_ready(cmd_reg)) begin
        state_next = ST_ISSUE;
      end
      ST_ISSUE: begin
        req_next   = 1'b1;
        state_next = ST_WAIT;
      end
      ST_WAIT: if (cyc_done) begin
        if (step.is_read) rdata_next = cyc_rdata;
        if (step.last) begin
          sec_next   = 1'b0;
          state_next = ST_IDLE;
        end else begin
          idx_next   = idx_reg + 3'd1;
          state_next = ST_ISSUE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      cmd_reg     <= CMD_READ;
      idx_reg     <= 3'd0;
      loc_reg     <= 18'h00000;
      word_reg    <= 16'h0000;
      rdata_reg   <= RDATA_RESET;
      sec_reg     <= 1'b0;
      devrst_reg  <= 1'b0;
      rst_n_reg   <= 1'b1;
      refused_reg <= 1'b0;
      ready_reg   <= 1'b0;
      req_reg     <= 1'b0;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cmd_reg     <= cmd_next;
      idx_reg     <= idx_next;
      loc_reg     <= loc_next;
      word_reg    <= word_next;
      rdata_reg   <= rdata_next;
      sec_reg     <= sec_next;
      devrst_reg  <= devrst_next;
      rst_n_reg   <= rst_n_next;
      refused_reg <= refused_next;
      ready_reg   <= ready_not_busy_pin;
      req_reg     <= req_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  fpc_bus_cycle u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (req_reg),
    .cyc     (step),
    .dq_in   (dq_in),
    .bus     (bus),
    .done    (cyc_done),
    .rdata   (cyc_rdata)
  );

  // Pin and bus outputs are all flop outputs gathered into their carriers.
  assign flash_out = '{bus: bus, rst_n: rst_n_reg, security_access_pin: sec_reg};
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_unlock_first;
    (state_reg == ST_ISSUE && idx_reg == 3'd0 && cmd_reg > CMD_RST1) |-> ##3
      (!flash_out.bus.we_n && flash_out.bus.addr == UNLOCK1_ADDR && flash_out.bus.dq_out == UNLOCK1_DATA);
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("first unlock write wrong");

  property p_unlock_second;
    (state_reg == ST_ISSUE && idx_reg == 3'd1) |-> ##3
      (!flash_out.bus.we_n && flash_out.bus.addr == UNLOCK2_ADDR && flash_out.bus.dq_out == UNLOCK2_DATA);
  endproperty
  a_unlock_second: assert property (p_unlock_second) else $error("second unlock write wrong");

  property p_upper_zero;
    (!flash_out.bus.we_n && !(cmd_reg == CMD_PROG && idx_reg == 3'd3)) |-> flash_out.bus.dq_out[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("command word upper byte not zero");

  property p_program_len;
    (state_reg == ST_WAIT && cyc_done && step.last && cmd_reg == CMD_PROG) |-> idx_reg == 3'd3 ##1 !busy;
  endproperty
  a_program_len: assert property (p_program_len) else $error("program sequence length wrong");

  property p_six_cycle;
    (state_reg == ST_WAIT && cyc_done && step.last &&
     (cmd_reg == CMD_CHIP || cmd_reg == CMD_BLOCK || cmd_reg == CMD_PROTECT || cmd_reg == CMD_SEC_OFF))
      |-> idx_reg == 3'd5;
  endproperty
  a_six_cycle: assert property (p_six_cycle) else $error("six-cycle sequence ended early");

  property p_verify_read;
    (state_reg == ST_ISSUE && cmd_reg == CMD_VERIFY && idx_reg == 3'd3) |-> ##3
      (!flash_out.bus.oe_n && flash_out.bus.dq_oe_n && !flash_out.bus.addr[5] && flash_out.bus.addr[0]);
  endproperty
  a_verify_read: assert property (p_verify_read) else $error("verify read address wrong");

  property p_sec_on;
    (state_reg == ST_ISSUE && cmd_reg == CMD_SEC_ON && idx_reg == 3'd3) |-> ##3
      (!flash_out.bus.we_n && flash_out.bus.addr == ZERO_ADDR && flash_out.bus.dq_out == CODE_SEC_ON &&
       flash_out.security_access_pin);
  endproperty
  a_sec_on: assert property (p_sec_on) else $error("security on final write wrong");

  property p_sec_off;
    (state_reg == ST_ISSUE && cmd_reg == CMD_SEC_OFF && idx_reg == 3'd5) |-> ##3
      (!flash_out.bus.we_n && flash_out.bus.addr == UNLOCK1_ADDR && flash_out.bus.dq_out == CODE_CHIP &&
       flash_out.security_access_pin);
  endproperty
  a_sec_off: assert property (p_sec_off) else $error("security off final write wrong");

  property p_sec_pin;
    flash_out.security_access_pin |-> (busy && fpc_is_security(cmd_reg));
  endproperty
  a_sec_pin: assert property (p_sec_pin) else $error("security pin high outside security command");

  property p_reset_no_wait;
    (state_reg == ST_WAITRDY && !fpc_needs_ready(cmd_reg)) |=> state_reg == ST_ISSUE ##1 req_reg;
  endproperty
  a_reset_no_wait: assert property (p_reset_no_wait) else $error("reset command held back by busy");

endmodule

`default_nettype wire

// ==== fpc_flash_model.sv ====
// Purpose: Behavioural flash array that stands on the far side of the programmer controller.
// Assumes: Pins are sampled on pclk; a write lands when the write strobe rises with chip select low.
// Notes:   Busy time is cut to BUSY_CYC clocks; block protect marks the block that holds 0x5555.
`default_nettype none

module fpc_flash_model import fpc_pkg::*; #(
  parameter int BUSY_CYC = 200
) (
  input  wire fpc_pins_type pins,
  input  wire logic         pclk,
  output var  logic [15:0]  dq_in,
  output var  logic         ready_not_busy_pin,
  output var  int           n_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [262144];
  logic [15:0] sd [6];
  logic [18:0] prot = '0;
  logic        tmo = 1'b0, secured = 1'b0, verify = 1'b0, prev_we_n = 1'b1;
  logic [15:0] pword = '0;
  int          step = 0, busy = 0, kind = 0;

  // The array powers up erased and ready.
  initial begin
    foreach (mem[k]) mem[k] = 16'hFFFF;
    dq_in = '0;
    ready_not_busy_pin = 1'b1;
    n_bad = 0;
  end

  // Fifteen large blocks, then the 8K, 4K and two 2K blocks; any location selects its block.
  function automatic int blk(input logic [17:0] a);
    return a < 18'h3C000 ? int'(a >> 14) : a < 18'h3E000 ? 15 : a < 18'h3F000 ? 16 : a < 18'h3F800 ? 17 : 18;
  endfunction

  // While an operation runs or has timed out, status replaces array data.
  function automatic logic [15:0] rdval(input logic [17:0] a);
    if (busy > 0 || tmo)
      return {8'h00, kind == 1 && !pword[7], 1'b0, tmo, 1'b0, tmo || (kind == 2 && busy < BUSY_CYC / 2), 3'b000};
    if (verify)
      return {15'h0000, prot[blk(a)]};
    return secured ? 16'h0098 : mem[a];
  endfunction

  // Whole-array erase with force also clears protected blocks, as security off does.
  task automatic erase(input int b, input logic all, input logic force_all);
    for (int k = 0; k < 262144; k++)
      if ((all || blk(18'(k)) == b) && (force_all || !prot[blk(18'(k))])) mem[k] = 16'hFFFF;
  endtask

  // One write cycle into the unlock decoder.
  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    logic fin, sec;
    if (d == CODE_RESET && (step == 0 || step == 2 && a == UNLOCK1_ADDR) && (busy == 0 || tmo)) begin
      step = 0;
      verify = 1'b0;
      tmo = 1'b0;
      busy = 0;
      return;
    end
    if (busy > 0 || tmo) return;
    fin = (step == 3 && sd[2] == CODE_PROGRAM) || step == 5;
    sec = (step == 3 && a == ZERO_ADDR && d == CODE_SEC_ON) || (step == 5 && sd[2] == CODE_ERASE && d == CODE_CHIP);
    if ((d[15:8] != 8'h00 && !(step == 3 && fin && !sec)) || (pins.security_access_pin && fin && !sec)) n_bad++;
    sd[step] = d;
    if (step == 3 && fin) begin
      pword = d;
      kind = 1;
      if (sec && pins.security_access_pin) secured = 1'b1;
      else if ((~mem[a] & d) != 16'h0000) tmo = 1'b1;
      else begin
        mem[a] = d;
        busy = BUSY_CYC;
      end
      step = 0;
    end else if (step == 5) begin
      if (d == CODE_BLOCK && sd[2] == CODE_ERASE && !pins.security_access_pin) erase(blk(a), 1'b0, 1'b0);
      else if (sec) erase(0, 1'b1, pins.security_access_pin);
      else if (sd[2] == CODE_PROTECT && d == CODE_PROTECT) prot[blk(a)] = 1'b1;
      if (sec && pins.security_access_pin) secured = 1'b0;
      kind = 2;
      busy = BUSY_CYC;
      step = 0;
    end else if ((step == 0 || step == 3) && a == UNLOCK1_ADDR && d == UNLOCK1_DATA ||
                 (step == 1 || step == 4) && a == UNLOCK2_ADDR && d == UNLOCK2_DATA ||
                 step == 2 && a == UNLOCK1_ADDR && (d == CODE_PROGRAM || d == CODE_ERASE || d == CODE_PROTECT)) begin
      step++;
    end else begin
      verify = step == 2 && a == UNLOCK1_ADDR && d == CODE_VERIFY;
      step = 0;
    end
  endtask

  // Strobes are sampled on the clock, since the controller holds each for several cycles.
  always @(posedge pclk) begin
    if (!pins.rst_n) begin
      step = 0;
      verify = 1'b0;
      tmo = 1'b0;
      busy = 0;
    end else if (!prev_we_n && pins.bus.we_n && !pins.bus.ce_n) wr(pins.bus.addr, pins.bus.dq_out);
    else if (busy > 0) busy--;
    if (verify && !pins.bus.oe_n && !pins.bus.ce_n && (pins.bus.addr[5] || !pins.bus.addr[0])) n_bad++;
    prev_we_n = pins.bus.we_n;
    ready_not_busy_pin <= busy == 0 && !tmo;
    // Released pins toggle so that a stale word never passes for a read result.
    dq_in <= (!pins.bus.ce_n && !pins.bus.oe_n && pins.rst_n) ? rdval(pins.bus.addr) : ~dq_in;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the APB flash programmer controller.
// Assumes: The flash model runs on the same clock with a shortened busy time.
// Notes:   All traffic goes through one APB task; expected words follow the command table.
`default_nettype none

module tb_top import fpc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic         pready, pslverr, ready_not_busy_pin;
  logic [7:0]   paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd;
  logic [15:0]  dq_in;
  logic [17:0]  locs [4] = '{18'h3EFFF, 18'h3F000, 18'h3F7FF, 18'h3F800};
  fpc_pins_type flash_out;
  int           n_bad, n_mismatch = 0, comparisons = 0, cyc = 0;

  fpc_top u_fpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(dq_in),
    .ready_not_busy_pin(ready_not_busy_pin), .flash_out(flash_out));
  fpc_flash_model u_fpc_flash_model (.pins(flash_out), .pclk(pclk), .dq_in(dq_in),
    .ready_not_busy_pin(ready_not_busy_pin), .n_bad(n_bad));

  // A 25 ns clock.
  initial forever #12.5 pclk = ~pclk;

  task automatic complete_run;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge; an idle cycle follows so strobes never collide.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Poll STATUS until the masked bits match; the watchdog cuts a hang short.
  task automatic wait_status(input logic [31:0] mask, input logic [31:0] want);
    do apb(1'b0, OFS_STATUS, '0); while ((rd & mask) !== want);
  endtask

  // Load location and word, start a command, wait for the controller, then fetch RDATA.
  task automatic run(input logic [3:0] cmd, input logic [17:0] loc, input logic [15:0] w);
    apb(1'b1, OFS_ADDR, {14'h0000, loc});
    apb(1'b1, OFS_WDATA, {16'h0000, w});
    apb(1'b1, OFS_CMD, {28'h0000000, cmd});
    wait_status(32'h1, 32'h0);
    apb(1'b0, OFS_RDATA, '0);
  endtask

  // Watchdog reckoned at several times the expected run length.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'({flash_out.bus.ce_n, flash_out.bus.oe_n, flash_out.bus.we_n, flash_out.bus.dq_oe_n,
               flash_out.rst_n, flash_out.security_access_pin}), 32'h3E);
    // Register reset values; STATUS shows the ready pin once it is registered.
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), '0);
      check(rd, i == 3 ? 32'h2 : 32'h0);
    end
    apb(1'b0, 8'h18, '0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h7);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFS_CMD, 32'hA);
    check({31'h0, err}, 32'h1);
    apb(1'b0, OFS_STATUS, '0);
    check(rd, 32'h6);
    // Program, then poll status while the array is busy; a second command back to back is refused.
    run(CMD_READ, 18'h00100, 16'h0);
    check(rd, 32'hFFFF);
    run(CMD_PROG, 18'h00100, 16'h1234);
    apb(1'b1, OFS_CMD, {28'h0000000, CMD_READ});
    apb(1'b1, OFS_CMD, {28'h0000000, CMD_READ});
    check({31'h0, err}, 32'h1);
    wait_status(32'h1, 32'h0);
    check(rd & 32'h2, 32'h0);
    apb(1'b0, OFS_RDATA, '0);
    check(rd, 32'h0080);
    wait_status(32'h3, 32'h2);
    run(CMD_READ, 18'h00100, 16'h0);
    check(rd, 32'h1234);
    // Programming a one over a zero times out; only the reset command recovers.
    run(CMD_PROG, 18'h00100, 16'hFFFF);
    run(CMD_READ, 18'h00100, 16'h0);
    check(rd, 32'h0028);
    apb(1'b0, OFS_STATUS, '0);
    check(rd, 32'h0);
    run(CMD_RST1, 18'h00100, 16'h0);
    wait_status(32'h3, 32'h2);
    run(CMD_READ, 18'h00100, 16'h0);
    check(rd, 32'h1234);
    // Protect verify before and after protecting the block that holds 0x5555.
    run(CMD_VERIFY, 18'h04123, 16'h0);
    check(rd, 32'h0);
    run(CMD_RST3, 18'h0, 16'h0);
    run(CMD_PROTECT, 18'h0, 16'h0);
    wait_status(32'h3, 32'h2);
    run(CMD_VERIFY, 18'h04123, 16'h0);
    check(rd, 32'h1);
    run(CMD_RST3, 18'h0, 16'h0);
    run(CMD_READ, 18'h00100, 16'h0);
    check(rd, 32'h1234);
    // Block erase by the first location of a block across the small top blocks, with the erase status window.
    foreach (locs[i]) begin
      run(CMD_PROG, locs[i], 16'h5A5A);
      wait_status(32'h3, 32'h2);
    end
    run(CMD_BLOCK, 18'h3F000, 16'h0);
    run(CMD_READ, 18'h3F000, 16'h0);
    check(rd, 32'h0000);
    repeat (100) @(posedge pclk);
    run(CMD_READ, 18'h3F000, 16'h0);
    check(rd, 32'h0008);
    wait_status(32'h3, 32'h2);
    foreach (locs[i]) begin
      run(CMD_READ, locs[i], 16'h0);
      check(rd, (i == 1 || i == 2) ? 32'hFFFF : 32'h5A5A);
    end
    // Security on hides the array; security off erases it and opens reads again.
    run(CMD_SEC_ON, 18'h0, 16'h0);
    run(CMD_READ, 18'h3F800, 16'h0);
    check(rd, 32'h0098);
    run(CMD_SEC_OFF, 18'h0, 16'h0);
    wait_status(32'h3, 32'h2);
    run(CMD_READ, 18'h3F800, 16'h0);
    check(rd, 32'hFFFF);
    // Chip erase with the security pin low clears a freshly programmed word.
    run(CMD_PROG, 18'h3F800, 16'h5A5A);
    wait_status(32'h3, 32'h2);
    run(CMD_CHIP, 18'h0, 16'h0);
    wait_status(32'h3, 32'h2);
    run(CMD_READ, 18'h3F800, 16'h0);
    check(rd, 32'hFFFF);
    // The hardware reset pin follows the pin control register.
    apb(1'b1, OFS_PINCTRL, 32'h1);
    check({31'h0, flash_out.rst_n}, 32'h0);
    apb(1'b1, OFS_PINCTRL, 32'h0);
    check(32'(n_bad), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
